// ==== hw/eoie_top.sv ====
// Top of the exit operand information encoder with its AHB-Lite register slave
//
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/100ps
//
// Behaviour
// RULE_01: segment code 0..5 in bits 17:15
// RULE_02: index codes 0..7 legacy registers, bits 21:18
// RULE_03: codes 8..15 only with 64-bit extension
// RULE_04: bit 22 set when no index register
// RULE_05: index code meaningless when bit 22 set
// RULE_06: base code in bits 26:23, same table
// RULE_07: bit 27 set when no base register
// RULE_08: address size 0/1/2 in bits 9:7
// RULE_09: bit 10 always zero
// RULE_10: operand size in bit 11
// RULE_11: whole word captured in exit cycle
module eoie_top
   import eoie_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic exit_commit,
   input wire logic [2:0] seg_sel,
   input wire logic [3:0] index_gpr_code,
   input wire logic index_absent,
   input wire logic [3:0] base_gpr_code,
   input wire logic base_absent,
   input wire logic [1:0] addr_size_sel,
   input wire logic op_size_32,
   output logic [31:0] exit_info_word
);
   // ----------------------------------------
   // Packing
   // ----------------------------------------
   eoie_pack_if pk_if ();
   logic [31:0] info_r;
   logic [31:0] info_nxt;
   logic [31:0] ctrl_r;
   logic [31:0] ctrl_nxt;
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;

   always_comb begin
      pk_if.operand.seg = seg_sel;
      pk_if.operand.index_gpr_code = index_gpr_code;
      pk_if.operand.index_none = index_absent;
      pk_if.operand.base_gpr_code = base_gpr_code;
      pk_if.operand.base_none = base_absent;
      pk_if.operand.addr_size = addr_size_sel;
      pk_if.operand.op_size_32 = op_size_32;
      pk_if.ext64_en = ctrl_r[EOIE_CTRL_EXT64_BIT];
   end

   eoie_field_packer u_packer (
      .pk(pk_if.packer)
   );

   // ----------------------------------------
   // Bus address phase capture
   // ----------------------------------------
   logic wr_pend_r;
   logic wr_pend_nxt;
   logic [7:0] addr_r;
   logic [7:0] addr_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic rd_hit;
   logic addr_taken;
   logic [31:0] rd_view;

   // hsize is not checked: every register is one whole word
   assign addr_taken = hsel && htrans[1] && hready;
   assign rd_hit = addr_taken && !hwrite;

   always_comb begin
      wr_pend_nxt = addr_taken && hwrite;
      addr_nxt = addr_r;
      if (addr_taken) begin
         addr_nxt = haddr[7:0];
      end
   end

   // ----------------------------------------
   // Read multiplexer
   // ----------------------------------------
   // Unmapped offsets read as zero rather than aliasing a register
   always_comb begin
      unique case (haddr[7:0])
         EOIE_OFF_INFO: rd_view = info_r;
         EOIE_OFF_CTRL: rd_view = ctrl_r;
         EOIE_OFF_STAT: rd_view = {16'h0000, cnt_r};
         default: rd_view = 32'h0000_0000;
      endcase
   end

   always_comb begin
      // Read data registered in the address phase: zero wait states
      rdata_nxt = rdata_r;
      if (rd_hit) begin
         rdata_nxt = rd_view;
      end
   end

   // ----------------------------------------
   // Bus state registers
   // ----------------------------------------
   // The address is kept for the write that lands one cycle later
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         addr_r <= 8'h00;
         rdata_r <= 32'h0000_0000;
      end else begin
         wr_pend_r <= wr_pend_nxt;
         addr_r <= addr_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   logic ctrl_wr;

   // Write data only stands in the data phase, one cycle after the address
   assign ctrl_wr = wr_pend_r && (addr_r == EOIE_OFF_CTRL);

   always_comb begin
      ctrl_nxt = ctrl_r;
      // Only the enable bit is writable; the rest reads as zero
      if (ctrl_wr) begin
         ctrl_nxt = {31'h0000_0000, hwdata[EOIE_CTRL_EXT64_BIT]}; // see RULE_03
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= EOIE_CTRL_RST;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // ----------------------------------------
   // Captured information word
   // ----------------------------------------
   always_comb begin
      info_nxt = info_r;
      // One register load of the whole word so software never sees a mix
      if (exit_commit) begin
         info_nxt = pk_if.word; // see RULE_11
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         info_r <= EOIE_INFO_RST;
      end else begin
         info_r <= info_nxt;
      end
   end

   // ----------------------------------------
   // Exit counter
   // ----------------------------------------
   // Counts every commit, back-to-back ones included
   always_comb begin
      cnt_nxt = cnt_r;
      // Wraps silently; software takes differences modulo the width
      if (exit_commit) begin
         cnt_nxt = cnt_r + 16'h0001;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= EOIE_CNT_RST;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // ----------------------------------------
   // Bus response
   // ----------------------------------------
   logic ready_nxt;
   logic resp_nxt;

   // Never stalls, always OKAY, so these are constant flops
   always_comb begin
      ready_nxt = 1'b1;
      resp_nxt = 1'b0;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= ready_nxt;
         hresp <= resp_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Both are plain flop outputs with no logic after them
   assign hrdata = rdata_r;
   assign exit_info_word = info_r;
endmodule : eoie_top

// ==== hw/eoie_pkg.sv ====
// Package for the exit operand information encoder: field layout, codes and register map
package eoie_pkg;
   // ----------------------------------------
   // Information word field positions
   // ----------------------------------------
   localparam int EOIE_ASZ_LSB = 7;
   localparam int EOIE_ASZ_MSB = 9;
   localparam int EOIE_ZERO_BIT = 10;
   localparam int EOIE_OSZ_BIT = 11;
   localparam int EOIE_SEG_LSB = 15;
   localparam int EOIE_SEG_MSB = 17;
   localparam int EOIE_IDX_LSB = 18;
   localparam int EOIE_IDX_MSB = 21;
   localparam int EOIE_IDX_INV_BIT = 22;
   localparam int EOIE_BASE_LSB = 23;
   localparam int EOIE_BASE_MSB = 26;
   localparam int EOIE_BASE_INV_BIT = 27;

   // ----------------------------------------
   // Codes
   // ----------------------------------------
   localparam logic [2:0] EOIE_SEG_MAX = 3'h5;
   localparam logic [2:0] EOIE_ASZ_16 = 3'h0;
   localparam logic [2:0] EOIE_ASZ_32 = 3'h1;
   localparam logic [2:0] EOIE_ASZ_64 = 3'h2;
   localparam logic [3:0] EOIE_GPR_LEGACY_MAX = 4'h7;

   // ----------------------------------------
   // Register map and reset values
   // ----------------------------------------
   localparam logic [7:0] EOIE_OFF_INFO = 8'h00;
   localparam logic [7:0] EOIE_OFF_CTRL = 8'h04;
   localparam logic [7:0] EOIE_OFF_STAT = 8'h08;
   localparam logic [31:0] EOIE_INFO_RST = 32'h0000_0000;
   localparam logic [31:0] EOIE_CTRL_RST = 32'h0000_0001;
   localparam int EOIE_CTRL_EXT64_BIT = 0;
   localparam int EOIE_STAT_CNT_LSB = 0;
   localparam int EOIE_STAT_CNT_MSB = 15;
   localparam logic [15:0] EOIE_CNT_RST = 16'h0000;

   // Operand detail as delivered by the decoder
   typedef struct packed {
      logic [2:0] seg;
      logic [3:0] index_gpr_code;
      logic index_none;
      logic [3:0] base_gpr_code;
      logic base_none;
      logic [1:0] addr_size;
      logic op_size_32;
   } eoie_operand_s;
endpackage : eoie_pkg

// ==== hw/eoie_pack_if.sv ====
// Interface carrying raw operand detail and the packed information word
`timescale 1ns/100ps
interface eoie_pack_if;
   import eoie_pkg::*;
   eoie_operand_s operand;
   logic ext64_en;
   logic [31:0] word;
   modport packer (input operand, input ext64_en, output word);
   modport user (output operand, output ext64_en, input word);
endinterface : eoie_pack_if

// ==== hw/eoie_field_packer.sv ====
// Combinational packer that forms the information word from operand detail
`timescale 1ns/100ps
module eoie_field_packer
   import eoie_pkg::*;
(
   eoie_pack_if.packer pk
);
   logic [2:0] seg_code;
   logic [3:0] idx_code;
   logic [3:0] base_code;
   logic [2:0] asz_code;

   // ----------------------------------------
   // Field coding
   // ----------------------------------------
   always_comb begin
      // Illegal selection folds to the last register so 6 and 7 never escape
      seg_code = (pk.operand.seg > EOIE_SEG_MAX) ? EOIE_SEG_MAX : pk.operand.seg; // see RULE_01
      // Extended registers only exist with the 64-bit extension
      idx_code = pk.operand.index_gpr_code; // see RULE_02
      base_code = pk.operand.base_gpr_code; // see RULE_06
      if (!pk.ext64_en) begin
         idx_code = {1'b0, pk.operand.index_gpr_code[2:0]}; // see RULE_03
         base_code = {1'b0, pk.operand.base_gpr_code[2:0]}; // see RULE_03
      end
      // Unused code is cleared rather than left floating
      if (pk.operand.index_none) begin
         idx_code = 4'h0; // see RULE_05
      end
      if (pk.operand.base_none) begin
         base_code = 4'h0; // see RULE_07
      end
      unique case (pk.operand.addr_size)
         2'h0: asz_code = EOIE_ASZ_16; // see RULE_08
         2'h1: asz_code = EOIE_ASZ_32;
         default: asz_code = pk.ext64_en ? EOIE_ASZ_64 : EOIE_ASZ_32;
      endcase
   end

   always_comb begin
      pk.word = EOIE_INFO_RST;
      pk.word[EOIE_ASZ_MSB:EOIE_ASZ_LSB] = asz_code;
      pk.word[EOIE_ZERO_BIT] = 1'b0; // see RULE_09
      pk.word[EOIE_OSZ_BIT] = pk.operand.op_size_32; // see RULE_10
      pk.word[EOIE_SEG_MSB:EOIE_SEG_LSB] = seg_code;
      pk.word[EOIE_IDX_MSB:EOIE_IDX_LSB] = idx_code;
      pk.word[EOIE_IDX_INV_BIT] = pk.operand.index_none; // see RULE_04
      pk.word[EOIE_BASE_MSB:EOIE_BASE_LSB] = base_code;
      pk.word[EOIE_BASE_INV_BIT] = pk.operand.base_none; // see RULE_07
   end
endmodule : eoie_field_packer

// ==== testbench/eoie_top_sva.sv ====
// Checker of the captured exit information word
`timescale 1ns/100ps
module eoie_top_sva (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic exit_commit,
   input wire logic [2:0] seg_sel,
   input wire logic [3:0] index_gpr_code,
   input wire logic index_absent,
   input wire logic [3:0] base_gpr_code,
   input wire logic base_absent,
   input wire logic [1:0] addr_size_sel,
   input wire logic op_size_32,
   input wire logic [31:0] exit_info_word
);
   // ----------------------------------------
   // Capture checks
   // ----------------------------------------
   logic [31:0] w;
   assign w = exit_info_word;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence s_cap;
      exit_commit ##1 1'b1;
   endsequence
   sequence s_idx_cap;
      (exit_commit && !index_absent) ##1 1'b1;
   endsequence
   sequence s_base_cap;
      (exit_commit && !base_absent) ##1 1'b1;
   endsequence
   property p_seg;
      s_cap |-> w[17:15] == (($past(seg_sel) > 3'h5) ? 3'h5 : $past(seg_sel));
   endproperty
   a_seg: assert property (p_seg) else $error("segment code");
   property p_seg_range;
      w[17:15] <= 3'h5;
   endproperty
   a_seg_range: assert property (p_seg_range) else $error("segment code 6 or 7");
   property p_idx;
      s_idx_cap |-> w[20:18] == $past(index_gpr_code[2:0]);
   endproperty
   a_idx: assert property (p_idx) else $error("index code");
   property p_idx_inv;
      s_cap |-> w[22] == $past(index_absent);
   endproperty
   a_idx_inv: assert property (p_idx_inv) else $error("index flag");
   property p_base;
      s_base_cap |-> w[25:23] == $past(base_gpr_code[2:0]);
   endproperty
   a_base: assert property (p_base) else $error("base code");
   property p_base_inv;
      s_cap |-> w[27] == $past(base_absent);
   endproperty
   a_base_inv: assert property (p_base_inv) else $error("base flag");
   property p_asz;
      (exit_commit && !addr_size_sel[1]) |=> w[9:7] == {1'b0, $past(addr_size_sel)};
   endproperty
   a_asz: assert property (p_asz) else $error("address size");
   property p_asz_range;
      w[9:7] <= 3'h2;
   endproperty
   a_asz_range: assert property (p_asz_range) else $error("address size code unused");
   property p_zero;
      w[10] == 1'b0;
   endproperty
   a_zero: assert property (p_zero) else $error("bit 10 set");
   property p_osz;
      s_cap |-> w[11] == $past(op_size_32);
   endproperty
   a_osz: assert property (p_osz) else $error("operand size");
   property p_hold;
      !exit_commit |=> $stable(w);
   endproperty
   a_hold: assert property (p_hold) else $error("word moved");
endmodule : eoie_top_sva

// ==== testbench/eoie_top_test.sv ====
// Self-checking bench of the exit operand information encoder
`timescale 1ns/100ps
module eoie_top_test;
   import eoie_pkg::*;
   // ----------------------------------------
   // Bench
   // ----------------------------------------
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, exit_commit, index_absent, base_absent;
   logic op_size_32;
   logic [31:0] haddr, hwdata, hrdata, exit_info_word, rd, ew, r;
   logic [1:0] htrans, addr_size_sel;
   logic [2:0] hsize, seg_sel;
   logic [3:0] index_gpr_code, base_gpr_code;
   int fails, n_tests, cyc;
   eoie_top u_eoie_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .exit_commit(exit_commit),
      .seg_sel(seg_sel), .index_gpr_code(index_gpr_code), .index_absent(index_absent),
      .base_gpr_code(base_gpr_code), .base_absent(base_absent),
      .addr_size_sel(addr_size_sel), .op_size_32(op_size_32), .exit_info_word(exit_info_word));
   function automatic logic [31:0] lfsr(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   // Index and base codes with no register are expected as 0, the designer's choice
   function automatic logic [31:0] expw(logic [15:0] v, logic ext);
      logic [31:0] w;
      w = 32'h0;
      w[9:7] = !v[14] ? {1'b0, v[14:13]} : (ext ? 3'h2 : 3'h1);
      w[11] = v[15];
      w[17:15] = (v[2:0] > 3'h5) ? 3'h5 : v[2:0];
      w[22] = v[7];
      w[27] = v[12];
      if (!v[7]) w[21:18] = v[6:3] & {ext, 3'h7};
      if (!v[12]) w[26:23] = v[11:8] & {ext, 3'h7};
      return w;
   endfunction : expw
   task automatic tally_and_finish();
      $display("fails %0d n_tests %0d", fails, n_tests);
      if (fails == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   task automatic cmp(logic [31:0] got, logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic bus(logic wr, logic [7:0] a, logic [31:0] wd);
      @(posedge hclk);
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      cmp({30'h0, hreadyout, hresp}, 32'h2);
   endtask : bus
   // Commits every cycle back to back; the first exit is a fixed corner case
   task automatic run(logic ext, int n);
      logic [31:0] m = 32'h0ffc_0000;
      for (int i = 0; i <= n; i++) begin
         @(posedge hclk);
         r = lfsr(r);
         if (i == 0) r[15:0] = 16'hef7f;
         {op_size_32, addr_size_sel, base_absent, base_gpr_code, index_absent, index_gpr_code,
            seg_sel} <= r[15:0];
         exit_commit <= (i < n);
         @(negedge hclk);
         if (i > 0) cmp(exit_info_word & ~m, ew & ~m);
         if (i > 0) cmp(exit_info_word & m, ew & m);
         if (i < n) ew = expw(r[15:0], ext);
      end
   endtask : run
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails++;
         tally_and_finish();
      end
   end
   initial begin
      {hsel, hwrite, exit_commit, op_size_32, index_absent, base_absent} = '0;
      {haddr, hwdata, htrans, addr_size_sel, seg_sel, index_gpr_code, base_gpr_code} = '0;
      hsize = 3'h2;
      hresetn = 1'b0;
      r = 32'h2c;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      hsel <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         bus(1'b0, 8'(k * 4), 32'h0);
         cmp(rd, {31'h0, k == 1});
      end
      run(1'b1, 24);
      bus(1'b1, 8'h00, 32'h5a5a_0f0f);
      bus(1'b0, 8'h00, 32'h0);
      cmp(rd, ew);
      bus(1'b0, 8'h08, 32'h0);
      cmp(rd, 32'h18);
      bus(1'b1, 8'h04, 32'hffff_ffff);
      bus(1'b0, 8'h04, 32'h0);
      cmp(rd, 32'h1);
      bus(1'b1, 8'h04, 32'h0);
      run(1'b0, 24);
      bus(1'b0, 8'h08, 32'h0);
      cmp(rd, 32'h30);
      @(posedge hclk);
      hresetn <= 1'b0;
      @(negedge hclk);
      cmp(exit_info_word, 32'h0);
      tally_and_finish();
   end
endmodule : eoie_top_test
bind eoie_top eoie_top_sva u_eoie_top_sva (.hclk(hclk), .hresetn(hresetn),
   .exit_commit(exit_commit), .seg_sel(seg_sel), .index_gpr_code(index_gpr_code),
   .index_absent(index_absent), .base_gpr_code(base_gpr_code), .base_absent(base_absent),
   .addr_size_sel(addr_size_sel), .op_size_32(op_size_32), .exit_info_word(exit_info_word));
